// ==== design/tms_key_mem.sv ====
`timescale 1ns/1ps
module tms_key_mem #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 24,
  parameter int AW = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);

  logic [WIDTH-1:0] mem [DEPTH];

  // array itself has no reset; the scan controller sweeps defaults in
  always_ff @(posedge clk_sys) begin
    if (we && (waddr < AW'(DEPTH))) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= (raddr_a < AW'(DEPTH)) ? mem[raddr_a] : '0;
      rdata_b <= (raddr_b < AW'(DEPTH)) ? mem[raddr_b] : '0;
    end
  end

endmodule

// ==== design/tms_pkg.sv ====
package tms_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int INIT_MAX_MS = 20;
  localparam int INIT_CYCLES = (CLK_HZ / 1000) * INIT_MAX_MS;
  localparam int RST_MIN_US = 10;
  localparam int RST_LOW_CYCLES = (CLK_HZ / 1000 * RST_MIN_US + 999) / 1000;
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // --------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_ACTIVE = 12'h00C;
  localparam logic [11:0] OFS_CFG_BASE = 12'h100;
  localparam logic [7:0] CMD_RECAL = 8'h55;
  localparam logic [15:0] SLEEP_MS_RST = 16'h007D;

  // ctrl: [15:0] sleep interval in ms
  // status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_AWAKE_BIT = 3;
  localparam int ST_SHIFT_BIT = 4;
  localparam int ST_ADDR_LSB = 5;
  localparam int ST_INITDONE_BIT = 12;
  localparam int ST_CALPEND_BIT = 13;

  // --------------------------------------------------------------------
  // per-key setup: [7:0] inner limit, [15:8] outer limit, [16] enable
  // --------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [7:0] outer_lim;
    logic [7:0] inner_lim;
  } tms_key_cfg_t;

  localparam logic [7:0] INNER_LIM_RST = 8'h02;
  localparam logic [7:0] OUTER_LIM_RST = 8'h03;
  localparam tms_key_cfg_t KEY_CFG_RST = '{en: 1'b1, outer_lim: OUTER_LIM_RST,
                                           inner_lim: INNER_LIM_RST};

  // burst request toward the acquisition front end
  typedef struct packed {
    logic cal;
    logic [4:0] key;
    logic [7:0] freq;
  } tms_burst_t;

  localparam logic [7:0] CHIRP_LO = 8'h10;
  localparam logic [7:0] CHIRP_HI = 8'hF0;

  // interface addresses chosen by the straps
  localparam logic [6:0] BUS_ADDR_01 = 7'h07;
  localparam logic [6:0] BUS_ADDR_10 = 7'h11;
  localparam logic [6:0] BUS_ADDR_11 = 7'h75;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_SLEEP = 3'b001,
    ST_FETCH = 3'b010,
    ST_CHECK = 3'b011,
    ST_BURST = 3'b100,
    ST_WAIT = 3'b101,
    ST_END = 3'b110
  } tms_state_t;

endpackage

// ==== design/tms_scan_ctrl.sv ====
`timescale 1ns/1ps
// Operation
// (RULE_01) initialization done within 20 ms
// (RULE_02) calibration completes within one matrix scan
// (RULE_03) disabled keys skipped in burst sequence
// (RULE_04) host holds reset pin low 10 us
// (RULE_05) pin reset equals full power-up state; the chirp sweep is not reset by the pin and keeps running
// (RULE_06) bursts always chirped, never configurable
// (RULE_07) inner counter advanced by repeated bursts
// (RULE_08) below threshold clears confirmation counter
// (RULE_09) inner limit per key, set via setups
// (RULE_10) outer counter steps when inner hits limit
// (RULE_11) inner failure also clears outer counter
// (RULE_12) outer limit reached marks key active
// (RULE_13) outer counter steps once per scan
// (RULE_14) sleep when idle, configurable wake interval
// (RULE_15) host communication wakes, serviced, then scan
// (RULE_16) one full scan after every wake
// (RULE_17) activity in last scan forces rescan
// (RULE_18) straps pick shift mode or address
// (RULE_19) reset clears counters and active flags
// (RULE_20) straps sampled once after reset
module tms_scan_ctrl #(
  parameter int NUM_KEYS = 24,
  parameter int INIT_CYCLES = tms_pkg::INIT_CYCLES,
  parameter int MS_CYCLES = tms_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic strap_select_low,
  input wire logic strap_select_high,
  input wire logic host_comm,
  output logic host_comm_ack,
  output logic awake,
  output logic iface_shift,
  output logic [6:0] iface_addr,
  output logic burst_req,
  output tms_pkg::tms_burst_t burst,
  input wire logic burst_done,
  input wire logic burst_over,
  output logic [NUM_KEYS-1:0] key_active,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  localparam int KW = 5;
  localparam logic [KW-1:0] LAST_KEY = KW'(NUM_KEYS - 1);

  tms_pkg::tms_state_t state_reg;
  logic clr;
  logic [8:0] pin_low_reg;
  logic [19:0] init_cnt_reg;
  logic [KW-1:0] key_reg;
  logic [7:0] inner_reg [NUM_KEYS];
  logic [7:0] outer_reg [NUM_KEYS];
  logic [NUM_KEYS-1:0] active_reg;
  logic [NUM_KEYS-1:0] visited_reg;
  logic activity_reg;
  logic cal_pend_reg;
  logic cal_scan_reg;
  logic comm_pend_reg;
  logic ack_reg;
  logic [15:0] sleep_ms_reg;
  logic [15:0] ms_cnt_reg;
  logic [15:0] tick_reg;
  logic strap_taken_reg;
  logic shift_reg;
  logic [6:0] addr_reg;
  logic [7:0] chirp_reg;
  logic chirp_up_reg;
  tms_pkg::tms_key_cfg_t cfg_a;
  logic [16:0] rd_a;
  logic [16:0] rd_b;
  logic mem_we;
  logic [KW-1:0] mem_waddr;
  logic [16:0] mem_wdata;
  logic [7:0] inner_next;
  logic inner_hit;
  logic outer_hit;
  logic scan_last;
  logic wake_now;
  logic ap_valid;
  logic dp_write_reg;
  logic dp_read_reg;
  logic [11:0] dp_addr_reg;
  logic cfg_hit;
  logic sweep;

  // --------------------------------------------------------------------
  // external reset pin: low for the minimum width acts as a power cycle for all but the chirp
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_low_reg <= '0;
    end else if (rst_pin_n) begin
      pin_low_reg <= '0;
    end else if (pin_low_reg != 9'(tms_pkg::RST_LOW_CYCLES)) begin
      pin_low_reg <= pin_low_reg + 9'h001; // RULE_04
    end
  end

  // all but the free-running chirp is held in its power-up state while the pin stays low past the minimum width
  assign clr = (pin_low_reg == 9'(tms_pkg::RST_LOW_CYCLES)); // RULE_05

  // --------------------------------------------------------------------
  // spread-spectrum chirp: free running, no software control at all
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chirp_reg <= tms_pkg::CHIRP_LO;
      chirp_up_reg <= 1'b1;
    end else if (chirp_up_reg) begin
      chirp_reg <= chirp_reg + 8'h01; // RULE_06
      chirp_up_reg <= (chirp_reg != tms_pkg::CHIRP_HI - 8'h01);
    end else begin
      chirp_reg <= chirp_reg - 8'h01; // RULE_06
      chirp_up_reg <= (chirp_reg == tms_pkg::CHIRP_LO + 8'h01);
    end
  end

  // --------------------------------------------------------------------
  // straps: caught on the first init cycle, frozen until the next reset
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_taken_reg <= 1'b0;
      shift_reg <= 1'b1;
      addr_reg <= 7'h00;
    end else if (clr) begin
      strap_taken_reg <= 1'b0;
      shift_reg <= 1'b1; // RULE_05
      addr_reg <= 7'h00;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1; // RULE_20
      shift_reg <= !strap_select_low && !strap_select_high; // RULE_18
      unique case ({strap_select_high, strap_select_low})
        2'b00: addr_reg <= 7'h00;
        2'b01: addr_reg <= tms_pkg::BUS_ADDR_01; // RULE_18
        2'b10: addr_reg <= tms_pkg::BUS_ADDR_10; // RULE_18
        2'b11: addr_reg <= tms_pkg::BUS_ADDR_11; // RULE_18
      endcase
    end
  end

  // --------------------------------------------------------------------
  // key setups memory: init sweep writes defaults, then the bus owns it
  // --------------------------------------------------------------------
  assign ap_valid = hsel && htrans[1] && hready;
  assign cfg_hit = (dp_addr_reg >= tms_pkg::OFS_CFG_BASE) &&
                   (dp_addr_reg[11:2] < 10'(tms_pkg::OFS_CFG_BASE[11:2]) + 10'(NUM_KEYS));
  assign sweep = (state_reg == tms_pkg::ST_INIT) && (init_cnt_reg < 20'(NUM_KEYS));
  assign mem_we = sweep || (dp_write_reg && cfg_hit);
  assign mem_waddr = sweep ? init_cnt_reg[KW-1:0] : KW'(dp_addr_reg[11:2]);
  assign mem_wdata = sweep ? tms_pkg::KEY_CFG_RST : hwdata[16:0]; // RULE_09

  tms_key_mem #(.WIDTH(17), .DEPTH(NUM_KEYS), .AW(KW)) u_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(key_reg),
    .rdata_a(rd_a),
    .raddr_b(KW'(haddr[11:2])),
    .rdata_b(rd_b)
  );
  assign cfg_a = rd_a;

  // --------------------------------------------------------------------
  // detection integrators
  // --------------------------------------------------------------------
  assign inner_next = inner_reg[key_reg] + 8'h01;
  assign inner_hit = (inner_next >= cfg_a.inner_lim);
  assign outer_hit = (outer_reg[key_reg] + 8'h01 >= cfg_a.outer_lim);
  assign scan_last = (key_reg == LAST_KEY);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        inner_reg[i] <= 8'h00; // RULE_19
        outer_reg[i] <= 8'h00; // RULE_19
      end
      active_reg <= '0; // RULE_19
      visited_reg <= '0;
    end else if (clr || state_reg == tms_pkg::ST_INIT) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        inner_reg[i] <= 8'h00; // RULE_19
        outer_reg[i] <= 8'h00; // RULE_19
      end
      active_reg <= '0; // RULE_19
      visited_reg <= '0;
    end else if (state_reg == tms_pkg::ST_FETCH && key_reg == '0) begin
      visited_reg <= '0;
    end else if (state_reg == tms_pkg::ST_WAIT && burst_done) begin
      if (cal_scan_reg || !burst_over) begin
        inner_reg[key_reg] <= 8'h00; // RULE_08
        outer_reg[key_reg] <= 8'h00; // RULE_11
        active_reg[key_reg] <= 1'b0;
      end else if (!inner_hit) begin
        inner_reg[key_reg] <= inner_next; // RULE_07
      end else begin
        inner_reg[key_reg] <= 8'h00;
        // one outer step per visit, and a key is visited once a scan
        if (!visited_reg[key_reg]) begin
          visited_reg[key_reg] <= 1'b1; // RULE_13
          outer_reg[key_reg] <= outer_hit ? outer_reg[key_reg]
                                          : outer_reg[key_reg] + 8'h01; // RULE_10
          if (outer_hit) begin
            active_reg[key_reg] <= 1'b1; // RULE_12
          end
        end
      end
    end
  end
  assign key_active = active_reg;

  // --------------------------------------------------------------------
  // scan sequencer
  // --------------------------------------------------------------------
  assign wake_now = comm_pend_reg || (tick_reg >= sleep_ms_reg); // RULE_14 RULE_15

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tms_pkg::ST_INIT;
      init_cnt_reg <= '0;
      key_reg <= '0;
    end else if (clr) begin
      state_reg <= tms_pkg::ST_INIT;
      init_cnt_reg <= '0;
      key_reg <= '0;
    end else begin
      unique case (state_reg)
        tms_pkg::ST_INIT: begin
          init_cnt_reg <= init_cnt_reg + 20'h00001;
          if (init_cnt_reg >= 20'(INIT_CYCLES - 1)) begin
            state_reg <= tms_pkg::ST_FETCH; // RULE_01
            key_reg <= '0;
          end
        end
        tms_pkg::ST_SLEEP: begin
          if (wake_now) begin
            state_reg <= tms_pkg::ST_FETCH; // RULE_16
            key_reg <= '0;
          end
        end
        tms_pkg::ST_FETCH: state_reg <= tms_pkg::ST_CHECK;
        tms_pkg::ST_CHECK: begin
          if (cfg_a.en) begin
            state_reg <= tms_pkg::ST_BURST;
          end else if (scan_last) begin
            state_reg <= tms_pkg::ST_END; // RULE_03
          end else begin
            key_reg <= key_reg + KW'(1); // RULE_03
            state_reg <= tms_pkg::ST_FETCH;
          end
        end
        tms_pkg::ST_BURST: state_reg <= tms_pkg::ST_WAIT;
        tms_pkg::ST_WAIT: begin
          if (burst_done) begin
            if (!cal_scan_reg && burst_over && !inner_hit) begin
              state_reg <= tms_pkg::ST_BURST; // RULE_07
            end else if (scan_last) begin
              state_reg <= tms_pkg::ST_END;
            end else begin
              key_reg <= key_reg + KW'(1);
              state_reg <= tms_pkg::ST_FETCH;
            end
          end
        end
        tms_pkg::ST_END: begin
          key_reg <= '0;
          if (activity_reg || comm_pend_reg) begin
            state_reg <= tms_pkg::ST_FETCH; // RULE_17
          end else begin
            state_reg <= tms_pkg::ST_SLEEP; // RULE_14
          end
        end
        default: state_reg <= tms_pkg::ST_INIT;
      endcase
    end
  end

  // touch seen anywhere in the current scan keeps the part awake
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      activity_reg <= 1'b0;
    end else if (clr || (state_reg == tms_pkg::ST_FETCH && key_reg == '0)) begin
      activity_reg <= 1'b0;
    end else if (state_reg == tms_pkg::ST_WAIT && burst_done && burst_over &&
                 !cal_scan_reg) begin
      activity_reg <= 1'b1; // RULE_17
    end
  end

  // calibration runs as the first scan after init or after a recal command
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cal_pend_reg <= 1'b1;
      cal_scan_reg <= 1'b0;
    end else if (clr) begin
      cal_pend_reg <= 1'b1;
      cal_scan_reg <= 1'b0;
    end else begin
      if (state_reg == tms_pkg::ST_FETCH && key_reg == '0) begin
        cal_scan_reg <= cal_pend_reg; // RULE_02
      end else if (state_reg == tms_pkg::ST_END) begin
        cal_scan_reg <= 1'b0; // RULE_02
      end
      // a recal written mid-scan waits for the next full scan
      if (dp_write_reg && dp_addr_reg == tms_pkg::OFS_CMD &&
          hwdata[7:0] == tms_pkg::CMD_RECAL) begin
        cal_pend_reg <= 1'b1;
      end else if (state_reg == tms_pkg::ST_FETCH && key_reg == '0) begin
        cal_pend_reg <= 1'b0;
      end
    end
  end

  // host traffic: set beats the acknowledge in the same cycle
  assign host_comm_ack = ack_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      comm_pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (clr) begin
      comm_pend_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= comm_pend_reg && state_reg == tms_pkg::ST_FETCH && key_reg == '0; // RULE_15
      if (host_comm) begin
        comm_pend_reg <= 1'b1; // RULE_15
      end else if (state_reg == tms_pkg::ST_FETCH && key_reg == '0) begin
        comm_pend_reg <= 1'b0;
      end
    end
  end

  // sleep timer in ms ticks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ms_cnt_reg <= '0;
      tick_reg <= '0;
    end else if (clr || state_reg != tms_pkg::ST_SLEEP) begin
      ms_cnt_reg <= '0;
      tick_reg <= '0;
    end else if (ms_cnt_reg >= 16'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= '0;
      tick_reg <= tick_reg + 16'h0001; // RULE_14
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  assign awake = (state_reg != tms_pkg::ST_SLEEP);
  assign iface_shift = shift_reg;
  assign iface_addr = addr_reg;
  assign burst_req = (state_reg == tms_pkg::ST_BURST);
  assign burst = '{cal: cal_scan_reg, key: key_reg, freq: chirp_reg}; // RULE_06

  // --------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dp_write_reg <= 1'b0;
      dp_read_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else if (hready) begin
      dp_write_reg <= ap_valid && hwrite;
      dp_read_reg <= ap_valid && !hwrite;
      dp_addr_reg <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ms_reg <= tms_pkg::SLEEP_MS_RST;
    end else if (clr) begin
      sleep_ms_reg <= tms_pkg::SLEEP_MS_RST;
    end else if (dp_write_reg && dp_addr_reg == tms_pkg::OFS_CTRL) begin
      sleep_ms_reg <= hwdata[15:0]; // RULE_14
    end
  end

  always_comb begin
    hrdata = 32'h00000000;
    if (dp_read_reg) begin
      if (cfg_hit) begin
        hrdata = {15'h0000, rd_b};
      end else begin
        unique case (dp_addr_reg)
          tms_pkg::OFS_CTRL: hrdata = {16'h0000, sleep_ms_reg};
          tms_pkg::OFS_STATUS: begin
            hrdata[tms_pkg::ST_STATE_LSB +: 3] = state_reg;
            hrdata[tms_pkg::ST_AWAKE_BIT] = awake;
            hrdata[tms_pkg::ST_SHIFT_BIT] = shift_reg;
            hrdata[tms_pkg::ST_ADDR_LSB +: 7] = addr_reg;
            hrdata[tms_pkg::ST_INITDONE_BIT] = (state_reg != tms_pkg::ST_INIT);
            hrdata[tms_pkg::ST_CALPEND_BIT] = cal_pend_reg;
          end
          tms_pkg::OFS_ACTIVE: hrdata = 32'(active_reg);
          default: hrdata = 32'h00000000;
        endcase
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// ==== testbench/tb_touch_matrix_scan_control.sv ====
`timescale 1ns/1ps
module tb_touch_matrix_scan_control;
  localparam int INIT = 100;
  localparam int MSC = 10;
  localparam logic [6:0] ADDRS [4] = '{7'h00, 7'h07, 7'h11, 7'h75};
  logic clk_sys, sys_rst, rst_pin_n, strap_select_low, strap_select_high;
  logic host_comm, host_comm_ack, awake, iface_shift, burst_req, burst_done, burst_over;
  logic [6:0] iface_addr;
  tms_pkg::tms_burst_t burst;
  logic [23:0] key_active, touch_mask;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lat;
  int fails = 0, check_count = 0, n_req = 0, n_cal = 0, n_k3 = 0, n_k5 = 0;

  tms_scan_ctrl #(.NUM_KEYS(24), .INIT_CYCLES(INIT), .MS_CYCLES(MSC)) DUT (
    .clk_sys, .sys_rst, .rst_pin_n, .strap_select_low, .strap_select_high, .host_comm,
    .host_comm_ack, .awake, .iface_shift, .iface_addr, .burst_req, .burst, .burst_done,
    .burst_over, .key_active, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp
  );
  tms_fe_model u_fe (
    .clk_sys, .sys_rst, .burst_req, .burst, .touch_mask, .lat, .burst_done, .burst_over
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (burst_req === 1'b1) begin
      n_req++;
      n_cal += burst.cal;
      n_k3 += (!burst.cal && burst.key == 5'h03);
      n_k5 += (burst.key == 5'h05);
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask
  task automatic do_reset(input logic [1:0] st);
    {strap_select_high, strap_select_low} <= st;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_straps;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      chk(iface_addr, ADDRS[s]);
      chk(iface_shift, s == 0);
      {strap_select_high, strap_select_low} <= ~s[1:0];
      repeat (4) @(posedge clk_sys);
      chk(iface_addr, ADDRS[s]);
    end
    $display("straps test done");
  endtask
  task automatic t_init;
    int n;
    do_reset(2'b01);
    chk(key_active, 0);
    repeat (24) @(posedge clk_sys);
    ahb(1'b0, 12'h000, 0);
    chk(rd, 32'h0000007D);
    ahb(1'b0, 12'h114, 0);
    chk(rd, 32'h00010302);
    ahb(1'b0, 12'h040, 0);
    chk(rd, 0);
    ahb(1'b0, 12'h008, 0);
    chk(rd, 32'h000020E8);
    ahb(1'b1, 12'h114, 32'h00000302);
    {n_req, n_cal, n_k5} = '0;
    for (n = 0; n < 300 && n_req == 0; n++) @(posedge clk_sys);
    chk(n <= INIT, 1);
    for (n = 0; n < 3000 && awake !== 1'b0; n++) @(posedge clk_sys);
    chk(n_cal, 23);
    chk(n_k5, 0);
    $display("init test done");
  endtask
  task automatic t_touch;
    int n, slp = 0;
    lat = 4'h6;
    do_reset(2'b01);
    repeat (30) @(posedge clk_sys);
    ahb(1'b1, 12'h10C, 32'h00010202);
    touch_mask <= 24'h000008;
    n_k3 = 0;
    for (n = 0; n < 5000 && key_active[3] !== 1'b1; n++) @(posedge clk_sys);
    chk(key_active, 32'h00000008);
    chk(n_k3, 4);
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      slp += (awake !== 1'b1);
    end
    chk(slp, 0);
    touch_mask <= 24'h000000;
    for (n = 0; n < 2000 && key_active !== 24'h0; n++) @(posedge clk_sys);
    chk(key_active, 0);
    ahb(1'b1, 12'h000, 32'h00000005);
    rst_pin_n <= 1'b0;
    repeat (252) @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, 12'h000, 0);
    chk(rd, 32'h0000007D);
    ahb(1'b0, 12'h10C, 0);
    chk(rd, 32'h00010302);
    $display("touch test done");
  endtask
  task automatic t_sleep;
    int n;
    lat = 4'h0;
    do_reset(2'b01);
    repeat (30) @(posedge clk_sys);
    ahb(1'b1, 12'h000, 32'h00000002);
    for (n = 0; n < 3000 && awake !== 1'b0; n++) @(posedge clk_sys);
    for (n = 0; n < 500 && awake !== 1'b1; n++) @(posedge clk_sys);
    chk(n >= MSC && n <= 2 * MSC + 3, 1);
    n_req = 0;
    ahb(1'b1, 12'h000, 32'h000003E8);
    for (n = 0; n < 3000 && awake !== 1'b0; n++) @(posedge clk_sys);
    chk(n_req, 24);
    repeat (50) @(posedge clk_sys);
    chk(awake, 0);
    host_comm <= 1'b1;
    @(posedge clk_sys);
    host_comm <= 1'b0;
    for (n = 0; n < 20 && host_comm_ack !== 1'b1; n++) @(posedge clk_sys);
    chk(n < 20, 1);
    chk(awake, 1);
    $display("sleep test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    rst_pin_n = 1'b1;
    {strap_select_high, strap_select_low} = 2'b01;
    host_comm = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    touch_mask = 24'h0;
    lat = 4'h2;
    t_straps;
    t_init;
    t_touch;
    t_sleep;
    report_and_stop;
  end
  initial begin
    // generous bound: the whole sequence needs well under a fifth of this
    repeat (60000) @(posedge clk_sys);
    fails++;
    report_and_stop;
  end
endmodule

// ==== testbench/tms_fe_model.sv ====
`timescale 1ns/1ps
module tms_fe_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic burst_req,
  input wire tms_pkg::tms_burst_t burst,
  input wire logic [23:0] touch_mask,
  input wire logic [3:0] lat,
  output logic burst_done,
  output logic burst_over
);
  // ------------------------------------------------------------
  // burst answer lat+1 cycles after the request is taken
  // ------------------------------------------------------------
  logic busy;
  logic [3:0] cnt;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      burst_done <= 1'b0;
      burst_over <= 1'b0;
    end else begin
      burst_done <= 1'b0;
      // result line toggles outside done so a stale level is never trusted
      burst_over <= ~burst_over;
      if (burst_req) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        burst_done <= 1'b1;
        burst_over <= touch_mask[burst.key];
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// ==== testbench/tms_scan_ctrl_sva.sv ====
`timescale 1ns/1ps
module tms_scan_chk #(
  parameter int NUM_KEYS = 24,
  parameter int INIT_CYCLES = 100
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic host_comm_ack,
  input wire logic awake,
  input wire logic iface_shift,
  input wire logic [6:0] iface_addr,
  input wire logic burst_req,
  input wire tms_pkg::tms_burst_t burst,
  input wire logic burst_done,
  input wire logic burst_over,
  input wire logic [NUM_KEYS-1:0] key_active
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // a pin low shorter than the filter also restarts the count; bench only uses full pulses
  logic [15:0] run_cnt;
  logic seen_req;
  logic [4:0] last_key;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst || !rst_pin_n) begin
      run_cnt <= 16'h0000;
      seen_req <= 1'b0;
    end else begin
      run_cnt <= run_cnt + {15'h0000, run_cnt != 16'hFFFF};
      seen_req <= seen_req | burst_req;
    end
  end
  always_ff @(posedge clk_sys) begin
    last_key <= burst.key;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !rst_pin_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_req_pulse: assert property (burst_req |=> !burst_req)
    else $error("burst request wider than one cycle");
  a_chirp_band: assert property (burst_req |-> burst.freq >= tms_pkg::CHIRP_LO
      && burst.freq <= tms_pkg::CHIRP_HI)
    else $error("burst frequency outside sweep");
  a_no_early: assert property (burst_req |-> run_cnt >= INIT_CYCLES)
    else $error("burst before init ended");
  a_init_bound: assert property (run_cnt == INIT_CYCLES + 40 |-> seen_req)
    else $error("no scan after init");
  a_reset_clean: assert property (run_cnt < INIT_CYCLES |-> key_active == '0)
    else $error("key active during init");
  a_strap_hold: assert property (run_cnt > 3 |-> $stable(iface_addr) && $stable(iface_shift))
    else $error("interface mode changed");
  a_strap_map: assert property (run_cnt > 2 |-> iface_shift == (iface_addr == 7'h00)
      && (iface_addr inside {7'h00, 7'h07, 7'h11, 7'h75}))
    else $error("bad interface address");
  a_ack_awake: assert property (host_comm_ack |-> awake ##1 !host_comm_ack)
    else $error("bad host ack");
  a_sleep_quiet: assert property (!awake |-> !burst_req)
    else $error("burst while asleep");
  a_key_release: assert property (burst_done && !burst_over |=> !key_active[last_key])
    else $error("key stayed active below threshold");
  a_touch_cause: assert property ((key_active & ~$past(key_active)) != '0
      |-> $past(burst_done && burst_over))
    else $error("key active without crossing");
endmodule

bind tms_scan_ctrl tms_scan_chk #(.NUM_KEYS(NUM_KEYS), .INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clk_sys, .sys_rst, .rst_pin_n, .host_comm_ack, .awake, .iface_shift, .iface_addr,
  .burst_req, .burst, .burst_done, .burst_over, .key_active
);
